// ===== gop_defines.vh
/*
 * constants for the six-pin general-purpose port with occupancy input.
 * assumes a 25 MHz system clock; included by gop_port.v.
 */
`ifndef GOP_DEFINES_VH
`define GOP_DEFINES_VH

`define GOP_PIN_COUNT      6
`define GOP_CLK_HZ         25000000
`define GOP_SECOND_S       1
`define GOP_CYC_PER_SEC    (`GOP_CLK_HZ * `GOP_SECOND_S)
`define GOP_TIME_MIN       7'h01
`define GOP_TIME_MAX       7'h78
`define GOP_POL_ACT_HIGH   1'h1
`define GOP_DIR_RESET      6'h00
`define GOP_OUT_RESET      6'h00

`endif

// ===== gop_port.v
/*
 * six general-purpose pins with per-pin direction, static level, timed level
 * and toggle, plus one occupancy sensor input with selectable polarity.
 * assumes the controlling logic issues one-cycle command strobes on mclk,
 * and that pin and sensor inputs are asynchronous to mclk.
 */
`timescale 1ns/100ps
`include "gop_defines.vh"

module gop_port #(
  parameter integer CYC_PER_SEC = `GOP_CYC_PER_SEC,
  parameter integer NPIN        = `GOP_PIN_COUNT
) (
  input  wire            mclk,
  input  wire            rst,
  input  wire            dirWrite,
  input  wire [2:0]      dirPin,
  input  wire            dirIsOutput,
  input  wire            levelWrite,
  input  wire [2:0]      levelPin,
  input  wire            levelValue,
  input  wire            timedWrite,
  input  wire [2:0]      timedPin,
  input  wire            timedValue,
  input  wire [6:0]      timedSeconds,
  input  wire            toggleWrite,
  input  wire [2:0]      togglePin,
  input  wire            polarityWrite,
  input  wire            polarityValue,
  input  wire [NPIN-1:0] pinIn,
  output reg  [NPIN-1:0] pinOut,
  output reg  [NPIN-1:0] pinOe_n,
  output reg  [NPIN-1:0] pinLevel,
  output wire [NPIN-1:0] pinDirOut,
  output reg  [NPIN-1:0] timedActive,
  output wire            timedReject,
  input  wire            occIn,
  output reg             occLevel,
  output reg             occOccupied,
  output wire            occupancy_polarity
);

  // =========================================================================
  // state
  reg  [NPIN-1:0] dir_q;
  reg  [NPIN-1:0] out_q;
  reg  [NPIN-1:0] saved_q;
  reg  [NPIN-1:0] timed_q;
  reg  [6:0]      secLeft_q [0:NPIN-1];
  reg  [31:0]     secPhase_q [0:NPIN-1];
  reg  [NPIN-1:0] secTick;
  reg  [NPIN-1:0] dirHit;
  reg  [NPIN-1:0] timedHit;
  reg  [NPIN-1:0] levelHit;
  reg  [NPIN-1:0] toggleHit;
  reg  [NPIN-1:0] pinSync1_q;
  reg  [NPIN-1:0] pinSync2_q;
  reg             occSync1_q;
  reg             occSync2_q;
  reg             pol_q;
  integer         i;
  integer         j;
  integer         k;

  function sel;
    input [2:0] pinIdx;
    input integer bitIdx;
    begin
      sel = (pinIdx == bitIdx[2:0]) && (pinIdx < NPIN);
    end
  endfunction

  function secEnd;
    input [31:0] phase;
    begin
      secEnd = (phase == CYC_PER_SEC - 1);
    end
  endfunction

  assign timedReject = timedWrite &&
                       ((timedSeconds < `GOP_TIME_MIN) || (timedSeconds > `GOP_TIME_MAX) || (timedPin >= NPIN));
  assign pinDirOut = dir_q;
  assign occupancy_polarity = pol_q;

  // =========================================================================
  // command decode per pin
  always @* begin
    dirHit    = {NPIN{1'b0}};
    timedHit  = {NPIN{1'b0}};
    levelHit  = {NPIN{1'b0}};
    toggleHit = {NPIN{1'b0}};
    secTick   = {NPIN{1'b0}};
    for (j = 0; j < NPIN; j = j + 1) begin
      dirHit[j]    = dirWrite && sel(dirPin, j);
      timedHit[j]  = timedWrite && !timedReject && sel(timedPin, j);
      levelHit[j]  = levelWrite && sel(levelPin, j);
      toggleHit[j] = toggleWrite && sel(togglePin, j);
      secTick[j]   = timed_q[j] && secEnd(secPhase_q[j]);
    end
  end

  // =========================================================================
  // per-pin one-second enable pulse
  // each interval restarts its own divider, so the first second is whole
  always @(posedge mclk) begin
    if (rst) begin
      for (k = 0; k < NPIN; k = k + 1) begin
        secPhase_q[k] <= 32'h00000000;
      end
    end else begin
      for (k = 0; k < NPIN; k = k + 1) begin
        if (timedHit[k] || secTick[k] || !timed_q[k]) begin
          secPhase_q[k] <= 32'h00000000;
        end else begin
          secPhase_q[k] <= secPhase_q[k] + 32'h00000001;
        end
      end
    end
  end

  // =========================================================================
  // direction per pin
  always @(posedge mclk) begin
    if (rst) begin
      dir_q <= `GOP_DIR_RESET;
    end else begin
      dir_q <= (dir_q & ~dirHit) | ({NPIN{dirIsOutput}} & dirHit);
    end
  end

  // =========================================================================
  // output level per pin; same-cycle priority is timed, level, toggle, expiry
  always @(posedge mclk) begin
    if (rst) begin
      out_q   <= `GOP_OUT_RESET;
      saved_q <= `GOP_OUT_RESET;
      timed_q <= {NPIN{1'b0}};
      for (i = 0; i < NPIN; i = i + 1) begin
        secLeft_q[i] <= 7'h00;
      end
    end else begin
      for (i = 0; i < NPIN; i = i + 1) begin
        if (timedHit[i]) begin
          // a restarted interval keeps the level saved by the first one
          if (!timed_q[i]) begin
            saved_q[i] <= out_q[i];
          end
          out_q[i]     <= timedValue;
          timed_q[i]   <= 1'b1;
          secLeft_q[i] <= timedSeconds;
        end else if (levelHit[i]) begin
          out_q[i]   <= levelValue;
          timed_q[i] <= 1'b0;
        end else if (toggleHit[i]) begin
          out_q[i]   <= ~out_q[i];
          timed_q[i] <= 1'b0;
        end else if (secTick[i]) begin
          if (secLeft_q[i] == 7'h01) begin
            out_q[i]   <= saved_q[i];
            timed_q[i] <= 1'b0;
          end
          secLeft_q[i] <= secLeft_q[i] - 7'h01;
        end
      end
    end
  end

  // =========================================================================
  // two-flop synchronisers for the asynchronous pin and sensor inputs
  always @(posedge mclk) begin
    if (rst) begin
      pinSync1_q <= {NPIN{1'b0}};
      pinSync2_q <= {NPIN{1'b0}};
      occSync1_q <= 1'b0;
      occSync2_q <= 1'b0;
    end else begin
      pinSync1_q <= pinIn;
      pinSync2_q <= pinSync1_q;
      occSync1_q <= occIn;
      occSync2_q <= occSync1_q;
    end
  end

  // =========================================================================
  // registered pin drive and readback
  always @(posedge mclk) begin
    if (rst) begin
      pinOut      <= {NPIN{1'b0}};
      pinOe_n     <= {NPIN{1'b1}};
      pinLevel    <= {NPIN{1'b0}};
      timedActive <= {NPIN{1'b0}};
    end else begin
      pinOut      <= out_q;
      pinOe_n     <= ~dir_q;
      // output pins read back their own level, input pins the synchronised pin
      pinLevel    <= (dir_q & out_q) | (~dir_q & pinSync2_q);
      timedActive <= timed_q;
    end
  end

  // =========================================================================
  // occupancy sensor: polarity, raw level and derived state
  always @(posedge mclk) begin
    if (rst) begin
      pol_q       <= `GOP_POL_ACT_HIGH;
      occLevel    <= 1'b0;
      occOccupied <= 1'b0;
    end else begin
      if (polarityWrite) begin
        pol_q <= polarityValue;
      end
      occLevel    <= occSync2_q;
      occOccupied <= ~(occSync2_q ^ pol_q);
    end
  end

endmodule

// ===== gop_port_chk.sv
/* port timing checker for gop_port.
   assumes it is bound to gop_port and sees only its ports. */
`timescale 1ns/100ps
module gop_port_chk (
  input wire       mclk,
  input wire       rst,
  input wire       timedWrite,
  input wire [6:0] timedSeconds,
  input wire       timedReject,
  input wire [5:0] timedActive,
  input wire [5:0] pinOe_n,
  input wire [5:0] pinDirOut,
  input wire       polarityWrite,
  input wire       polarityValue,
  input wire       occupancy_polarity,
  input wire       occIn,
  input wire       occLevel,
  input wire       occOccupied
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  AST_RST_POL: assert property ($fell(rst) |-> occupancy_polarity) else $error("bad polarity");
  AST_RST_OE: assert property ($fell(rst) |-> pinOe_n == 6'h3F && timedActive == 6'h00) else $error("bad reset");
  AST_OE_DIR: assert property (pinOe_n == ~$past(pinDirOut)) else $error("enable off dir");
  AST_REJ: assert property (timedWrite && (timedSeconds == 7'h00 || timedSeconds > 7'h78) |-> timedReject) else $error("no reject");
  AST_TIMED: assert property (timedWrite && !timedReject |-> ##2 timedActive != 6'h00) else $error("no interval");
  AST_POL_WR: assert property (polarityWrite |=> occupancy_polarity == $past(polarityValue)) else $error("pol lost");
  AST_OCC: assert property (occOccupied == (occLevel == $past(occupancy_polarity))) else $error("bad state");
  AST_OCC_LVL: assert property ($rose(occLevel) |-> $past(occIn, 3)) else $error("bad level");
  COV_TIMED: cover property (timedWrite && !timedReject);
  COV_REJ: cover property (timedReject);
  COV_OCC: cover property ($rose(occOccupied));
endmodule
bind gop_port gop_port_chk gop_port_chk_inst (.*);

// ===== gop_far.sv
/* equipment on the pins and the occupancy sensor.
   assumes the bench sets the sensor level and the equipment's pin levels. */
`timescale 1ns/100ps
module gop_far (
  input  wire [5:0] pinOut,
  input  wire [5:0] pinOe_n,
  input  wire [5:0] extSet,
  input  wire       occSet,
  output wire [5:0] pinIn,
  output wire       occIn
);
  // output pins echo the block's drive, input pins carry the equipment's level
  assign pinIn = (pinOut & ~pinOe_n) | (extSet & pinOe_n);
  assign occIn = occSet;
endmodule

// ===== gop_port_test.sv
/* self-checking bench for gop_port.
   assumes gop_far and gop_port_chk are compiled. */
`timescale 1ns/100ps
module gop_port_test;
  logic mclk = 0, rst = 1, occSet = 0, v;
  logic dirWrite = 0, levelWrite = 0, timedWrite = 0, toggleWrite = 0, polarityWrite = 0;
  logic dirIsOutput = 0, levelValue = 0, timedValue = 0, polarityValue = 0;
  logic [2:0] dirPin = 0, levelPin = 0, timedPin = 0, togglePin = 0, p;
  logic [6:0] timedSeconds = 0;
  logic [5:0] ex, prev, dirs, extSet = 0;
  wire [5:0] pinIn, pinOut, pinOe_n, pinLevel, pinDirOut, timedActive;
  wire timedReject, occIn, occLevel, occOccupied, occupancy_polarity;
  int err_count = 0, compares = 0, i, n;
  localparam int SEC_CYC = 10;
  gop_port #(.CYC_PER_SEC(SEC_CYC)) gop_port_inst (.*);
  gop_far gop_far_inst (.*);
  initial forever #20 mclk = ~mclk;
  initial begin
    #40000;
    err_count++;
    stop_test;
  end
  task chk(string s, logic [6:0] seen, logic [6:0] want);
    compares++;
    if (seen !== want) begin
      err_count++;
      $display("[ERR] %s exp %h seen %h", s, want, seen);
    end
  endtask
  // one strobe of kind k: dir, level, timed, toggle, polarity
  task cmd(int k, logic [2:0] pn, logic vv, logic [6:0] s);
    @(posedge mclk);
    {dirWrite, levelWrite, timedWrite, toggleWrite, polarityWrite} <= 5'h10 >> k;
    {dirPin, levelPin, timedPin, togglePin} <= {4{pn}};
    {dirIsOutput, levelValue, timedValue, polarityValue} <= {4{vv}};
    timedSeconds <= s;
    #1 chk("reject", timedReject, k == 2 && (s == 0 || s > 120 || pn > 5));
    @(posedge mclk);
    {dirWrite, levelWrite, timedWrite, toggleWrite, polarityWrite} <= 5'h00;
    repeat (2) @(posedge mclk);
    #1;
  endtask
  function logic [5:0] bit1(logic [2:0] pn);
    return 6'h01 << pn;
  endfunction
  task stop_test;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    void'($urandom(77));
    repeat (8) @(posedge mclk);
    rst <= 0;
    @(posedge mclk) #1;
    chk("pol", occupancy_polarity, 1);
    chk("oe", pinOe_n, 7'h3F);
    dirs = $urandom;
    for (i = 0; i < 6; i++) cmd(0, i, dirs[i], 0);
    chk("oe", pinOe_n, {1'b0, ~dirs});
    chk("dir", pinDirOut, dirs);
    ex = 6'h00;
    for (i = 0; i < 30; i++) begin
      @(posedge mclk) extSet <= $urandom;
      p = $urandom % 8;
      v = $urandom;
      n = $urandom % 2;
      cmd(n ? 3 : 1, p, v, 0);
      if (p < 6) ex = n ? ex ^ bit1(p) : v ? ex | bit1(p) : ex & ~bit1(p);
      chk("out", pinOut, ex);
      chk("pinlevel", pinLevel, (dirs & ex) | (~dirs & extSet));
    end
    prev = ex;
    cmd(2, 2, ~ex[2], 2);
    chk("timed", pinOut, ex ^ 6'h04);
    chk("active", timedActive, 7'h04);
    for (n = 0; n < 40 && timedActive !== 0; n++) @(posedge mclk) #1;
    chk("span", n, 2 * SEC_CYC - 1);
    chk("restore", pinOut, prev);
    cmd(2, 1, 1, 0);
    cmd(2, 1, 1, 121);
    cmd(2, 7, 1, 5);
    chk("refused", timedActive, 0);
    cmd(2, 1, 1, 120);
    chk("long", timedActive, 7'h02);
    cmd(1, 1, 0, 0);
    chk("cancel", timedActive, 0);
    chk("cancelout", pinOut, ex & ~6'h02);
    for (i = 0; i < 4; i++) begin
      cmd(4, 0, i[1], 0);
      @(posedge mclk) occSet <= i[0];
      repeat (4) @(posedge mclk);
      #1 chk("level", occLevel, i[0]);
      chk("occ", occOccupied, i[0] == i[1]);
      chk("pol", occupancy_polarity, i[1]);
    end
    stop_test;
  end
endmodule
